// file: hw/spt_device.sv
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
`include "spt_regs.svh"
module spt_device (
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output spt_pkg::spt_resp_t s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output spt_pkg::spt_resp_t s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    spt_if.dev port_io
);
    function automatic logic [7:0] merge(input logic [7:0] old_v,
                                         input logic [31:0] wd,
                                         input logic [3:0] strb);
        merge = strb[0] ? wd[7:0] : old_v;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == `SPT_OFS_CONTROL) || (a == `SPT_OFS_PORT_D) ||
                 (a == `SPT_OFS_D_DIR) || (a == `SPT_OFS_PORT_E) ||
                 (a == `SPT_OFS_E_LATCH) || (a == `SPT_OFS_E_DIR) ||
                 (a == `SPT_OFS_IRQ_FLAGS);
    endfunction

    // bus slave state
    logic [7:0] awaddr_q;
    logic aw_got_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic w_got_q;
    logic do_wr;
    logic do_rd;

    // block state
    logic mode_q;
    logic in_full_q;
    logic out_full_q;
    logic in_ovf_q;
    logic irq_q;
    logic [7:0] in_latch_q;
    logic [7:0] out_latch_q;
    logic [7:0] d_dir_q;
    logic [2:0] e_lat_q;
    logic [2:0] e_dir_q;
    logic [2:0] strb_m_q;
    logic [2:0] strb_s_q;
    logic [7:0] pd_m_q;
    logic [7:0] pd_s_q;
    logic [7:0] wr_cap_q;
    logic wr_act_q;
    logic rd_act_q;
    logic [7:0] pd_out_q;
    logic pd_oe_q;
    logic [2:0] pe_out_q;
    logic [2:0] pe_oe_q;

    logic wr_now;
    logic rd_now;
    logic wr_end;
    logic rd_beg;
    logic rd_end;
    logic sel_ctrl;
    logic sel_pd;
    logic sel_ddir;
    logic sel_elat;
    logic sel_edir;
    logic sel_irq;
    logic cpu_rd_pd;
    logic [7:0] out_latch_d;
    logic [7:0] rd_val;

    // ---------------- bus slave ----------------
    assign do_wr = aw_got_q && w_got_q && !s_axi_bvalid;
    assign do_rd = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge clk) begin
        if (srst) begin
            aw_got_q <= 1'b0;
            s_axi_awready <= 1'b1;
            awaddr_q <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_got_q <= 1'b1;
            s_axi_awready <= 1'b0;
            awaddr_q <= s_axi_awaddr;
        end else if (s_axi_bvalid && s_axi_bready) begin
            aw_got_q <= 1'b0;
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            w_got_q <= 1'b0;
            s_axi_wready <= 1'b1;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_got_q <= 1'b1;
            s_axi_wready <= 1'b0;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end else if (s_axi_bvalid && s_axi_bready) begin
            w_got_q <= 1'b0;
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= spt_pkg::RESP_OKAY;
        end else if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(awaddr_q) ? spt_pkg::RESP_OKAY
                                            : spt_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_comb begin
        sel_ctrl = 1'b0;
        sel_pd = 1'b0;
        sel_ddir = 1'b0;
        sel_elat = 1'b0;
        sel_edir = 1'b0;
        sel_irq = 1'b0;
        if (!do_wr) begin
            sel_ctrl = 1'b0;
        end else if (awaddr_q == `SPT_OFS_CONTROL) begin
            sel_ctrl = wstrb_q[0];
        end else if (awaddr_q == `SPT_OFS_PORT_D) begin
            sel_pd = wstrb_q[0];
        end else if (awaddr_q == `SPT_OFS_D_DIR) begin
            sel_ddir = wstrb_q[0];
        end else if (awaddr_q == `SPT_OFS_E_LATCH) begin
            sel_elat = wstrb_q[0];
        end else if (awaddr_q == `SPT_OFS_E_DIR) begin
            sel_edir = wstrb_q[0];
        end else if (awaddr_q == `SPT_OFS_IRQ_FLAGS) begin
            sel_irq = wstrb_q[0];
        end
    end

    always_comb begin
        rd_val = 8'h00;
        if (s_axi_araddr == `SPT_OFS_CONTROL) begin
            // low nibble unimplemented
            rd_val = {in_full_q, out_full_q, in_ovf_q,
                      mode_q, 4'h0};
        end else if (s_axi_araddr == `SPT_OFS_PORT_D) begin
            rd_val = mode_q ? in_latch_q : pd_s_q;
        end else if (s_axi_araddr == `SPT_OFS_D_DIR) begin
            rd_val = d_dir_q;
        end else if (s_axi_araddr == `SPT_OFS_PORT_E) begin
            rd_val = {5'h00, strb_s_q};
        end else if (s_axi_araddr == `SPT_OFS_E_LATCH) begin
            rd_val = {5'h00, e_lat_q};
        end else if (s_axi_araddr == `SPT_OFS_E_DIR) begin
            rd_val = {5'h00, e_dir_q};
        end else if (s_axi_araddr == `SPT_OFS_IRQ_FLAGS) begin
            rd_val = {irq_q, 7'h00};
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= spt_pkg::RESP_OKAY;
        end else if (do_rd) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_val};
            s_axi_rresp <= mapped(s_axi_araddr) ? spt_pkg::RESP_OKAY
                                                : spt_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
        end
    end

    // ---------------- slave port ----------------
    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (srst) begin
            strb_m_q <= 3'h7;
            strb_s_q <= 3'h7;
            pd_m_q <= 8'h00;
            pd_s_q <= 8'h00;
        end else begin
            strb_m_q <= {port_io.cs_line, port_io.wr_line,
                         port_io.rd_line};
            strb_s_q <= strb_m_q;
            pd_m_q <= port_io.data_line;
            pd_s_q <= pd_m_q;
        end
    end

    assign wr_now = mode_q && !strb_s_q[2] && !strb_s_q[1];
    assign rd_now = mode_q && !strb_s_q[2] && !strb_s_q[0];
    assign wr_end = wr_act_q && !wr_now;
    assign rd_beg = rd_now && !rd_act_q;
    assign rd_end = rd_act_q && !rd_now;
    assign cpu_rd_pd = do_rd && mode_q && (s_axi_araddr == `SPT_OFS_PORT_D);
    assign out_latch_d = sel_pd ? merge(out_latch_q, wdata_q, wstrb_q)
                                : out_latch_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            wr_act_q <= 1'b0;
            rd_act_q <= 1'b0;
            wr_cap_q <= 8'h00;
        end else begin
            wr_act_q <= wr_now;
            rd_act_q <= rd_now;
            // data is taken while the strobe is still low, not after
            if (wr_now) begin
                wr_cap_q <= pd_s_q;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            in_latch_q <= 8'h00;
        end else if (wr_end) begin
            in_latch_q <= wr_cap_q;
        end
    end

    // status flags: a hardware set wins over a same-cycle clear
    always_ff @(posedge clk) begin
        if (srst) begin
            in_full_q <= 1'b0;
            out_full_q <= 1'b0;
            in_ovf_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            if (wr_end) begin
                in_full_q <= 1'b1;
            end else if (cpu_rd_pd) begin
                in_full_q <= 1'b0;
            end
            if (rd_beg) begin
                out_full_q <= 1'b1;
            end else if (sel_pd && !rd_act_q) begin
                out_full_q <= 1'b0;
            end
            if (wr_end && in_full_q && !cpu_rd_pd) begin
                in_ovf_q <= 1'b1;
            end else if (sel_ctrl && !wdata_q[`SPT_BIT_IN_OVF]) begin
                in_ovf_q <= 1'b0;
            end
            if (wr_end || rd_end) begin
                irq_q <= 1'b1;
            end else if (sel_irq && !wdata_q[`SPT_BIT_IRQ]) begin
                irq_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            mode_q <= 1'b0;
            out_latch_q <= 8'h00;
            d_dir_q <= `SPT_RST_D_DIR;
            e_lat_q <= 3'h0;
            e_dir_q <= `SPT_RST_E_DIR;
        end else begin
            if (sel_ctrl) begin
                mode_q <= wdata_q[`SPT_BIT_MODE];
            end
            out_latch_q <= out_latch_d;
            if (sel_ddir) begin
                d_dir_q <= merge(d_dir_q, wdata_q, wstrb_q);
            end
            if (sel_elat) begin
                e_lat_q <= wdata_q[2:0];
            end
            if (sel_edir) begin
                e_dir_q <= wdata_q[2:0];
            end
        end
    end

    // pin drivers; new port D latch data reaches the pins the edge it is written, port E latch data one edge later
    always_ff @(posedge clk) begin
        if (srst) begin
            pd_out_q <= 8'h00;
            pd_oe_q <= 1'b0;
            pe_out_q <= 3'h0;
            pe_oe_q <= 3'h0;
        end else begin
            pd_out_q <= out_latch_d;
            // direction bits are overridden while the slave port runs
            pd_oe_q <= mode_q ? rd_now : (d_dir_q == 8'h00);
            pe_out_q <= e_lat_q;
            pe_oe_q <= mode_q ? 3'h0 : ~e_dir_q;
        end
    end

    assign port_io.data_d = pd_out_q;
    assign port_io.data_d_oe = pd_oe_q;
    assign port_io.pe_d = pe_out_q;
    assign port_io.pe_d_oe = pe_oe_q;
endmodule

// file: hw/spt_host.sv
`timescale 1ns/100ps
`include "spt_regs.svh"
module spt_host #(
    parameter int STROBE_CYC = `SPT_STROBE_CYC,
    parameter int RECOV_CYC = `SPT_RECOV_CYC
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output spt_pkg::spt_resp_t s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output spt_pkg::spt_resp_t s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    spt_if.host port_io
);
    spt_pkg::spt_hstate_t st_q;
    logic [7:0] awaddr_q;
    logic aw_got_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic w_got_q;
    logic do_wr;
    logic go;
    logic is_rd_q;
    logic done_q;
    logic [7:0] rdat_q;
    logic [7:0] cnt_q;
    logic cs_n_q;
    logic rd_n_q;
    logic wr_n_q;
    logic [7:0] dout_q;
    logic doe_q;

    assign do_wr = aw_got_q && w_got_q && !s_axi_bvalid;
    // commands are ignored while a cycle is still running
    assign go = do_wr && (awaddr_q == `SPT_OFS_CMD)
        && (st_q == spt_pkg::ST_IDLE)
        && (wdata_q[`SPT_BIT_GO_WR] || wdata_q[`SPT_BIT_GO_RD]);

    always_ff @(posedge clk) begin
        if (srst) begin
            aw_got_q <= 1'b0;
            s_axi_awready <= 1'b1;
            awaddr_q <= 8'h00;
            w_got_q <= 1'b0;
            s_axi_wready <= 1'b1;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q <= 1'b1;
                s_axi_awready <= 1'b0;
                awaddr_q <= s_axi_awaddr;
            end else if (s_axi_bvalid && s_axi_bready) begin
                aw_got_q <= 1'b0;
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q <= 1'b1;
                s_axi_wready <= 1'b0;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (s_axi_bvalid && s_axi_bready) begin
                w_got_q <= 1'b0;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= spt_pkg::RESP_OKAY;
        end else if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_q == `SPT_OFS_CMD) ? spt_pkg::RESP_OKAY
                                                     : spt_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= spt_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            if (s_axi_araddr == `SPT_OFS_STATUS) begin
                s_axi_rdata <= {16'h0000, rdat_q, 6'h00, done_q,
                                st_q != spt_pkg::ST_IDLE};
                s_axi_rresp <= spt_pkg::RESP_OKAY;
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= spt_pkg::RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
        end
    end

    // one strobe cycle: setup, strobe low, hold, recovery gap
    always_ff @(posedge clk) begin
        if (srst) begin
            st_q <= spt_pkg::ST_IDLE;
            cnt_q <= 8'h00;
            is_rd_q <= 1'b0;
            done_q <= 1'b0;
            rdat_q <= 8'h00;
            cs_n_q <= 1'b1;
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            dout_q <= 8'h00;
            doe_q <= 1'b0;
        end else begin
            case (st_q)
                spt_pkg::ST_IDLE: begin
                    if (go) begin
                        is_rd_q <= wdata_q[`SPT_BIT_GO_RD];
                        dout_q <= wdata_q[7:0];
                        doe_q <= !wdata_q[`SPT_BIT_GO_RD];
                        cs_n_q <= 1'b0;
                        done_q <= 1'b0;
                        st_q <= spt_pkg::ST_SETUP;
                    end
                end
                spt_pkg::ST_SETUP: begin
                    rd_n_q <= !is_rd_q;
                    wr_n_q <= is_rd_q;
                    cnt_q <= 8'(STROBE_CYC - 1);
                    st_q <= spt_pkg::ST_STROBE;
                end
                spt_pkg::ST_STROBE: begin
                    if (cnt_q == 8'h00) begin
                        // strobe rises first, ending the device's cycle
                        rd_n_q <= 1'b1;
                        wr_n_q <= 1'b1;
                        if (is_rd_q) begin
                            rdat_q <= port_io.data_line;
                        end
                        st_q <= spt_pkg::ST_HOLD;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                spt_pkg::ST_HOLD: begin
                    cs_n_q <= 1'b1;
                    doe_q <= 1'b0;
                    cnt_q <= 8'(RECOV_CYC - 1);
                    st_q <= spt_pkg::ST_RECOV;
                end
                spt_pkg::ST_RECOV: begin
                    if (cnt_q == 8'h00) begin
                        done_q <= 1'b1;
                        st_q <= spt_pkg::ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                default: begin
                    st_q <= spt_pkg::ST_IDLE;
                end
            endcase
        end
    end

    assign port_io.cs_n_h = cs_n_q;
    assign port_io.rd_n_h = rd_n_q;
    assign port_io.wr_n_h = wr_n_q;
    assign port_io.data_h = dout_q;
    assign port_io.data_h_oe = doe_q;
endmodule

// file: hw/spt_if.sv
`timescale 1ns/100ps
interface spt_if;
    logic cs_n_h;
    logic rd_n_h;
    logic wr_n_h;
    logic [7:0] data_h;
    logic data_h_oe;
    logic [7:0] data_d;
    logic data_d_oe;
    logic [2:0] pe_d;
    logic [2:0] pe_d_oe;
    // resolved wire levels; undriven data floats high as with pull-ups
    logic cs_line;
    logic rd_line;
    logic wr_line;
    logic [7:0] data_line;
    assign rd_line = pe_d_oe[0] ? pe_d[0] : rd_n_h;
    assign wr_line = pe_d_oe[1] ? pe_d[1] : wr_n_h;
    assign cs_line = pe_d_oe[2] ? pe_d[2] : cs_n_h;
    assign data_line = data_d_oe ? data_d : (data_h_oe ? data_h : 8'hFF);
    modport dev (
        input cs_line, rd_line, wr_line, data_line,
        output data_d, data_d_oe, pe_d, pe_d_oe
    );
    modport host (
        input data_line,
        output cs_n_h, rd_n_h, wr_n_h, data_h, data_h_oe
    );
endinterface

// file: hw/spt_pkg.sv
package spt_pkg;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_SETUP = 5'h02,
        ST_STROBE = 5'h04,
        ST_HOLD = 5'h08,
        ST_RECOV = 5'h10
    } spt_hstate_t;
    typedef logic [1:0] spt_resp_t;
    localparam spt_resp_t RESP_OKAY = 2'h0;
    localparam spt_resp_t RESP_SLVERR = 2'h2;
endpackage

// file: hw/spt_regs.svh
`ifndef SPT_REGS_SVH
`define SPT_REGS_SVH

// device register map, byte addresses
`define SPT_OFS_CONTROL 8'h00
`define SPT_OFS_PORT_D 8'h04
`define SPT_OFS_D_DIR 8'h08
`define SPT_OFS_PORT_E 8'h0C
`define SPT_OFS_E_LATCH 8'h10
`define SPT_OFS_E_DIR 8'h14
`define SPT_OFS_IRQ_FLAGS 8'h18
// control and irq flag fields
`define SPT_BIT_IN_FULL 7
`define SPT_BIT_OUT_FULL 6
`define SPT_BIT_IN_OVF 5
`define SPT_BIT_MODE 4
`define SPT_BIT_IRQ 7
// reset values
`define SPT_RST_D_DIR 8'hFF
`define SPT_RST_E_DIR 3'h7
// host controller map
`define SPT_OFS_CMD 8'h00
`define SPT_OFS_STATUS 8'h04
`define SPT_BIT_GO_WR 8
`define SPT_BIT_GO_RD 9
`define SPT_BIT_BUSY 0
`define SPT_BIT_DONE 1
// timing
`define SPT_CLK_NS 25
`define SPT_STROBE_NS 200
`define SPT_RECOV_NS 100
`define SPT_STROBE_CYC ((`SPT_STROBE_NS + `SPT_CLK_NS - 1) / `SPT_CLK_NS)
`define SPT_RECOV_CYC ((`SPT_RECOV_NS + `SPT_CLK_NS - 1) / `SPT_CLK_NS)
`endif

// file: tb/spt_chk.sv
`timescale 1ns/100ps
module spt_chk (
    input wire logic clk,
    input wire logic srst,
    input wire logic cs_n_h,
    input wire logic rd_n_h,
    input wire logic wr_n_h,
    input wire logic data_h_oe,
    input wire logic data_d_oe,
    input wire logic cs_line,
    input wire logic rd_line
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // read must hold past both sync stages before the device may answer
    sequence rd_held;
        (!cs_line && !rd_line) [*5];
    endsequence
    sequence wr_open;
        !cs_n_h ##1 $fell(wr_n_h);
    endsequence
    a_drive_on_read:
        assert property (rd_held |-> data_d_oe)
        else $error("device not driving during a read");
    a_drive_not_early:
        assert property ($rose(data_d_oe) |-> $past(!cs_line && !rd_line, 2))
        else $error("device drove before strobes were synchronised");
    a_release_end:
        assert property ((cs_line || rd_line) && data_d_oe |-> ##[1:5] !data_d_oe)
        else $error("device kept driving after read end");
    a_no_contention:
        assert property (!(data_d_oe && data_h_oe))
        else $error("both ends drive the data lines");
    a_write_frame:
        assert property (wr_open |-> (!wr_n_h && !cs_n_h && data_h_oe) [*7])
        else $error("write strobe or data dropped early");
    a_cs_release:
        assert property ($rose(wr_n_h) |-> ##1 $rose(cs_n_h))
        else $error("select not released after write strobe");
    a_recovery:
        assert property ($rose(cs_n_h) |-> cs_n_h [*3])
        else $error("select recovery too short");
    a_read_frame:
        assert property ($fell(rd_n_h) |-> $past(!cs_n_h) && !data_h_oe)
        else $error("read strobe without select or with host drive");
endmodule

// file: tb/test_parallel_slave_port.sv
`timescale 1ns/100ps
module test_parallel_slave_port;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] aw [2], ar [2];
    logic [31:0] wd [2], rd [2];
    logic [1:0] br [2], rr [2];
    logic awv [2], awr [2], wv [2], wrd [2], bv [2], bq [2];
    logic arv [2], arr [2], rv [2], rq [2];
    logic [31:0] rdat;
    logic [1:0] rsp;
    int fail_count = 0;
    int checks_done = 0;
    logic [7:0] rows [4] = '{8'h00, 8'hA5, 8'h5A, 8'hFF};
    spt_if link();
    spt_device spt_device_i (.clk(clk), .srst(srst), .s_axi_awaddr(aw[0]),
        .s_axi_awvalid(awv[0]), .s_axi_awready(awr[0]),
        .s_axi_wdata(wd[0]), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv[0]),
        .s_axi_wready(wrd[0]), .s_axi_bresp(br[0]), .s_axi_bvalid(bv[0]),
        .s_axi_bready(bq[0]), .s_axi_araddr(ar[0]), .s_axi_arvalid(arv[0]),
        .s_axi_arready(arr[0]), .s_axi_rdata(rd[0]), .s_axi_rresp(rr[0]),
        .s_axi_rvalid(rv[0]), .s_axi_rready(rq[0]), .port_io(link));
    spt_host spt_host_i (.clk(clk), .srst(srst), .s_axi_awaddr(aw[1]),
        .s_axi_awvalid(awv[1]), .s_axi_awready(awr[1]),
        .s_axi_wdata(wd[1]), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv[1]),
        .s_axi_wready(wrd[1]), .s_axi_bresp(br[1]), .s_axi_bvalid(bv[1]),
        .s_axi_bready(bq[1]), .s_axi_araddr(ar[1]), .s_axi_arvalid(arv[1]),
        .s_axi_arready(arr[1]), .s_axi_rdata(rd[1]), .s_axi_rresp(rr[1]),
        .s_axi_rvalid(rv[1]), .s_axi_rready(rq[1]), .port_io(link));
    spt_chk spt_chk_i (.clk(clk), .srst(srst), .cs_n_h(link.cs_n_h),
        .rd_n_h(link.rd_n_h), .wr_n_h(link.wr_n_h),
        .data_h_oe(link.data_h_oe), .data_d_oe(link.data_d_oe),
        .cs_line(link.cs_line), .rd_line(link.rd_line));
    always #12.5 clk = ~clk;
    task end_of_test;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", n, e, g);
            fail_count++;
        end
    endtask
    // s selects the slave: 0 device registers, 1 host controller
    task axw(input int s, input logic [7:0] a, input logic [31:0] d);
        aw[s] <= a;
        wd[s] <= d;
        awv[s] <= 1'b1;
        wv[s] <= 1'b1;
        do begin
            @(posedge clk);
            if (awr[s] === 1'b1) awv[s] <= 1'b0;
            if (wrd[s] === 1'b1) wv[s] <= 1'b0;
        end while (bv[s] !== 1'b1);
        rsp = br[s];
    endtask
    task axr(input int s, input logic [7:0] a);
        ar[s] <= a;
        arv[s] <= 1'b1;
        do begin
            @(posedge clk);
            if (arr[s] === 1'b1) arv[s] <= 1'b0;
        end while (rv[s] !== 1'b1);
        rdat = rd[s];
        rsp = rr[s];
    endtask
    task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
        axr(0, a);
        chk(n, e, rdat);
    endtask
    // leaves the final status word, with the read byte, in rdat
    task xfer(input logic [31:0] cmd);
        axw(1, 8'h00, cmd);
        do axr(1, 8'h04); while (rdat[1] !== 1'b1);
    endtask
    initial begin
        repeat (30000) @(posedge clk);
        $display("[FAIL] watchdog expected finish seen timeout");
        fail_count++;
        end_of_test;
    end
    initial begin
        for (int i = 0; i < 2; i++) begin
            {aw[i], ar[i], wd[i]} = '0;
            {awv[i], wv[i], arv[i]} = '0;
            // responses are always accepted at once
            {bq[i], rq[i]} = 2'h3;
        end
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        rchk("ctl reset", 8'h00, 32'h0);
        rchk("d dir reset", 8'h08, 32'hFF);
        rchk("e dir reset", 8'h14, 32'h7);
        rchk("e pins idle", 8'h0C, 32'h7);
        axw(0, 8'h14, 32'h7);
        axr(0, 8'h40);
        chk("unmapped", 32'(spt_pkg::RESP_SLVERR), 32'(rsp));
        xfer(32'h13C);
        rchk("irq idle", 8'h18, 32'h0);
        rchk("ctl idle", 8'h00, 32'h0);
        axw(0, 8'h00, 32'hDF);
        chk("wr resp", 32'(spt_pkg::RESP_OKAY), 32'(rsp));
        rchk("ctl ro bits", 8'h00, 32'h10);
        $display("test regs done");
        foreach (rows[i]) begin
            axw(0, 8'h04, {24'h0, ~rows[i]});
            xfer(32'h100 | {24'h0, rows[i]});
            rchk("ctl after wr", 8'h00, 32'h90);
            rchk("irq after wr", 8'h18, 32'h80);
            rchk("byte in", 8'h04, {24'h0, rows[i]});
            rchk("ctl cleared", 8'h00, 32'h10);
            axw(0, 8'h18, 32'h0);
            xfer(32'h200);
            chk("byte out", {24'h0, ~rows[i]}, {24'h0, rdat[15:8]});
            rchk("ctl after rd", 8'h00, 32'h50);
            rchk("irq after rd", 8'h18, 32'h80);
            axw(0, 8'h18, 32'h0);
        end
        $display("test rows done");
        axw(0, 8'h04, 32'h0);
        xfer(32'h111);
        xfer(32'h122);
        rchk("overflow", 8'h00, 32'hB0);
        axw(0, 8'h00, 32'h10);
        rchk("overflow cleared", 8'h00, 32'h90);
        rchk("newest byte", 8'h04, 32'h22);
        $display("test overflow done");
        // cpu rewrites the latch while the host read is under way
        axw(0, 8'h04, 32'h0);
        axw(1, 8'h00, 32'h200);
        repeat (3) @(posedge clk);
        axw(0, 8'h04, 32'h3C);
        do axr(1, 8'h04); while (rdat[1] !== 1'b1);
        chk("late byte", 32'h3C, {24'h0, rdat[15:8]});
        rchk("ctl late", 8'h00, 32'h50);
        $display("test late write done");
        axw(0, 8'h00, 32'h10);
        xfer(32'h133);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        rchk("ctl rereset", 8'h00, 32'h0);
        rchk("irq rereset", 8'h18, 32'h0);
        $display("test reset done");
        end_of_test;
    end
endmodule
